// ===== src/fsic_pkg.sv
// fsic_pkg: constants and types shared by the four-source interrupt controller
// assumes: single 250 MHz clock domain, registers reached over the peripheral port
package fsic_pkg;

   // ****************************************************************
   // peripheral register map
   // ****************************************************************
   localparam logic [3:0] INTERRUPT_ENABLE_CONTROL_IDX = 4'ha;
   localparam logic [3:0] ENABLE_RESET                  = 4'h0;
   localparam logic [3:0] FLAG_RESET                    = 4'h0;
   localparam logic [10:0] VEC_RESET                    = 11'h000;

   // ****************************************************************
   // enable bit positions, also the priority order (0 highest)
   // ****************************************************************
   localparam int SRC_EXT    = 0;
   localparam int SRC_TMR1   = 1;
   localparam int SRC_TMR2   = 2;
   localparam int SRC_SERIAL = 3;
   localparam int NUM_SRC    = 4;

   // ****************************************************************
   // vector addresses
   // ****************************************************************
   localparam logic [10:0] VEC_EXT    = 11'h010;
   localparam logic [10:0] VEC_TMR1   = 11'h020;
   localparam logic [10:0] VEC_TMR2   = 11'h030;
   localparam logic [10:0] VEC_SERIAL = 11'h040;

   // ****************************************************************
   // sequencer states
   // ****************************************************************
   typedef enum logic [1:0] {
      FSIC_IDLE  = 2'b00,
      FSIC_ENTRY = 2'b01,
      FSIC_SERVE = 2'b11
   } fsic_state_t;

endpackage

// ===== src/fsic_sync.sv
// fsic_sync: two-stage synchroniser for one asynchronous level
// assumes: clock and async active-low reset of the receiving domain
`timescale 1ns/1ps
`default_nettype none
module fsic_sync (
   // clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // level
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_r;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         meta_r   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ===== src/fsic_prio.sv
// fsic_prio: fixed priority pick among request flags and vector lookup
// assumes: bit 0 highest priority
`timescale 1ns/1ps
`default_nettype none
module fsic_prio (
   // requests
   input  wire logic [3:0]  req,
   // winner
   output logic             any,
   output logic [1:0]       idx,
   output logic [10:0]      vector
);
   always_comb begin
      any    = 1'b1;
      idx    = 2'd0;
      vector = fsic_pkg::VEC_EXT;
      if (req[fsic_pkg::SRC_EXT]) begin
         idx    = 2'd0;
         vector = fsic_pkg::VEC_EXT;
      end else if (req[fsic_pkg::SRC_TMR1]) begin
         idx    = 2'd1;
         vector = fsic_pkg::VEC_TMR1;
      end else if (req[fsic_pkg::SRC_TMR2]) begin
         idx    = 2'd2;
         vector = fsic_pkg::VEC_TMR2;
      end else if (req[fsic_pkg::SRC_SERIAL]) begin
         idx    = 2'd3;
         vector = fsic_pkg::VEC_SERIAL;
      end else begin
         any    = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== src/fsic_top.sv
// fsic_top: four-source interrupt controller beside a 4-bit cpu sequencer
// assumes: cpu performs the context stack moves when told; peripherals give one-cycle pulses
// Operation
// - fixed priority: external edge, timer 1, timer 2, serial lowest.
// - vectors are 10h external, 20h timer 1, 30h timer 2, 40h serial.
// - no nesting; requests during a handler wait until it returns.
// - entry pushes pc, accumulator, x, x', y', page pointer, status, then loads vector.
// - return instruction clears serviced flag, restores context, resumes program.
// - disabled source never sets its request flag; its event is dropped.
// - external request comes from a rising edge on the external pin.
// - external edge during halt is latched and served after halt ends.
// - timer flags separate from overflow; cleared by return, timer start, reset.
// - serial flag sets with transmission end when enabled; cleared by return, reset.
// - an enabled internal source enters at an instruction boundary after its flag sets, when idle and not halted.
// - enable register holds bits 0 to 3, read/write at peripheral index 10.
// - internal events while disabled are ignored, not remembered.
// - clearing enables during a handler stops pending requests; handler finishes.
`timescale 1ns/1ps
`default_nettype none
module fsic_top #(
   // source count
   parameter int NUM_SOURCES = 4
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // external pin
   input  wire logic        external_request_pin,
   // peripheral register port
   input  wire logic [3:0]  periph_index,
   input  wire logic        periph_write,
   input  wire logic [3:0]  periph_wdata,
   output logic      [3:0]  periph_rdata,
   // peripheral events
   input  wire logic        timer1_overflow,
   input  wire logic        timer2_overflow,
   input  wire logic        timer1_start,
   input  wire logic        timer2_start,
   input  wire logic        serial_tx_end,
   // cpu sequencer
   input  wire logic        halt_standby,
   input  wire logic        instr_boundary,
   input  wire logic        return_from_handler_instr,
   input  wire logic        context_saved,
   output logic             context_push,
   output logic             context_pop,
   output logic             vector_load,
   output logic      [10:0] vector_addr,
   output logic             in_handler,
   output logic      [3:0]  request_flags
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      fsic_pkg::fsic_state_t st;
      logic [3:0]            enable;
      logic [3:0]            flag;
      logic [1:0]            active;
      logic [10:0]           vec;
      logic                  pin_d;
      logic                  push;
      logic                  pop;
      logic                  vload;
   } fsic_regs_t;

   fsic_regs_t state_r;
   fsic_regs_t state_nxt;

   logic             pin_s;
   logic             win_any;
   logic [1:0]       win_idx;
   logic [10:0]      win_vec;
   logic [3:0]       event_v;
   logic [3:0]       eligible;
   logic             writing_ctl;
   logic             take_entry;
   logic             take_return;
   wire logic [3:0]  event_raw;
   wire logic [3:0]  start_clear;
   wire logic [3:0]  clear_v;
   wire logic [3:0]  flag_next;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   // the priority pick and vector table serve exactly four sources
   if (NUM_SOURCES != fsic_pkg::NUM_SRC) begin : g_bad_sources
      $error("fsic_top: only four interrupt sources are supported");
   end

   // ****************************************************************
   // pin synchroniser and priority pick
   // ****************************************************************
   fsic_sync u_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .async_in (external_request_pin),
      .sync_out (pin_s)
   );

   fsic_prio u_prio (
      .req    (eligible),
      .any    (win_any),
      .idx    (win_idx),
      .vector (win_vec)
   );

   // ****************************************************************
   // register write decode
   // ****************************************************************
   assign writing_ctl = periph_write &&
                        (periph_index == fsic_pkg::INTERRUPT_ENABLE_CONTROL_IDX);

   // ****************************************************************
   // event capture
   // ****************************************************************
   // pin edge from the synchronised level against its delayed copy
   assign event_raw[fsic_pkg::SRC_EXT]    = pin_s && !state_r.pin_d;
   assign event_raw[fsic_pkg::SRC_TMR1]   = timer1_overflow;
   assign event_raw[fsic_pkg::SRC_TMR2]   = timer2_overflow;
   assign event_raw[fsic_pkg::SRC_SERIAL] = serial_tx_end;

   // disabled events leave no trace
   assign event_v = event_raw & state_r.enable;

   // ****************************************************************
   // request flag clears and sets
   // ****************************************************************
   assign take_return = (state_r.st == fsic_pkg::FSIC_SERVE) &&
                        return_from_handler_instr;

   // timer start clears only the timer flags
   assign start_clear[fsic_pkg::SRC_EXT]    = 1'b0;
   assign start_clear[fsic_pkg::SRC_TMR1]   = timer1_start;
   assign start_clear[fsic_pkg::SRC_TMR2]   = timer2_start;
   assign start_clear[fsic_pkg::SRC_SERIAL] = 1'b0;

   // set wins over clear in the same cycle
   for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_flag
      assign clear_v[i]   = (take_return && (state_r.active == 2'(i))) || start_clear[i];
      assign flag_next[i] = event_v[i] || (state_r.flag[i] && !clear_v[i]);
   end

   // ****************************************************************
   // entry decision
   // ****************************************************************
   // pending flags die with their enable but stay stored
   assign eligible = state_r.flag & state_r.enable;

   // halt holds off entry; a latched edge waits in its flag
   assign take_entry = (state_r.st == fsic_pkg::FSIC_IDLE) && win_any &&
                       instr_boundary && !halt_standby;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_nxt       = state_r;
      state_nxt.push  = 1'b0;
      state_nxt.pop   = 1'b0;
      state_nxt.vload = 1'b0;
      state_nxt.pin_d = pin_s;
      state_nxt.flag  = flag_next;
      if (writing_ctl) begin
         state_nxt.enable = periph_wdata;
      end

      case (state_r.st)
         fsic_pkg::FSIC_IDLE: begin
            if (take_entry) begin
               state_nxt.st     = fsic_pkg::FSIC_ENTRY;
               state_nxt.active = win_idx;
               state_nxt.vec    = win_vec;
               state_nxt.push   = 1'b1;
            end
         end
         fsic_pkg::FSIC_ENTRY: begin
            if (context_saved) begin
               state_nxt.vload = 1'b1;
               state_nxt.st    = fsic_pkg::FSIC_SERVE;
            end
         end
         fsic_pkg::FSIC_SERVE: begin
            // new requests stay pending while serving
            if (take_return) begin
               state_nxt.pop = 1'b1;
               state_nxt.st  = fsic_pkg::FSIC_IDLE;
            end
         end
         default: begin
            state_nxt.st = fsic_pkg::FSIC_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r.st     <= fsic_pkg::FSIC_IDLE;
         state_r.enable <= fsic_pkg::ENABLE_RESET;
         state_r.flag   <= fsic_pkg::FLAG_RESET;
         state_r.active <= 2'd0;
         state_r.vec    <= fsic_pkg::VEC_RESET;
         state_r.pin_d  <= 1'b0;
         state_r.push   <= 1'b0;
         state_r.pop    <= 1'b0;
         state_r.vload  <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_comb begin
      periph_rdata = 4'h0;
      if (periph_index == fsic_pkg::INTERRUPT_ENABLE_CONTROL_IDX) begin
         periph_rdata = state_r.enable;
      end
   end

   assign context_push  = state_r.push;
   assign context_pop   = state_r.pop;
   assign vector_load   = state_r.vload;
   assign vector_addr   = state_r.vec;
   assign in_handler    = (state_r.st != fsic_pkg::FSIC_IDLE);
   assign request_flags = state_r.flag;

endmodule
`default_nettype wire

// ===== sim/fsic_monitor.sv
// fsic_monitor: port checks for fsic_top
// assumes: bound to fsic_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fsic_monitor (
   // clock and reset
   input wire logic        clock,
   input wire logic        reset_n,
   // register port
   input wire logic [3:0]  periph_index,
   input wire logic        periph_write,
   input wire logic [3:0]  periph_wdata,
   input wire logic [3:0]  periph_rdata,
   // cpu side
   input wire logic        halt_standby,
   input wire logic        return_from_handler_instr,
   input wire logic        context_saved,
   input wire logic        context_push,
   input wire logic        context_pop,
   input wire logic        vector_load,
   input wire logic [10:0] vector_addr,
   input wire logic        in_handler,
   input wire logic [3:0]  request_flags
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_wr; periph_write && periph_index == 4'ha; endsequence
   sequence s_ret; in_handler && return_from_handler_instr; endsequence
   property p_wr; s_wr ##1 periph_index == 4'ha |-> periph_rdata == $past(periph_wdata);
   endproperty
   a_wr: assert property (p_wr) else $error("enable readback wrong");
   property p_unmap; periph_index != 4'ha |-> periph_rdata == 4'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_cause; context_push |-> $past(request_flags) != 4'h0; endproperty
   a_cause: assert property (p_cause) else $error("entry without flag");
   property p_nonest; in_handler |=> !context_push; endproperty
   a_nonest: assert property (p_nonest) else $error("nested entry");
   property p_halt; halt_standby |=> !context_push; endproperty
   a_halt: assert property (p_halt) else $error("entry during halt");
   property p_load; context_saved && in_handler |=> vector_load; endproperty
   a_load: assert property (p_load) else $error("vector not loaded");
   property p_vec;
      vector_load |-> vector_addr inside {11'h010, 11'h020, 11'h030, 11'h040};
   endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_ret; s_ret |=> context_pop && !in_handler; endproperty
   a_ret: assert property (p_ret) else $error("return not handled");
   property p_push; $rose(in_handler) |-> context_push; endproperty
   a_push: assert property (p_push) else $error("entry without context push");
endmodule
`default_nettype wire

// ===== sim/fsic_cpu_model.sv
// fsic_cpu_model: cpu sequencer answering context pushes
// assumes: bench asks for returns via ret_go
`timescale 1ns/1ps
`default_nettype none
module fsic_cpu_model (
   // clock and reset
   input wire logic  clock,
   input wire logic  reset_n,
   // bench controls
   input wire logic  slow,
   input wire logic  ret_go,
   // controller side
   input wire logic  context_push,
   output var logic  context_saved,
   output var logic  return_from_handler_instr
);
   logic [3:0] cnt_r;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 4'h0;
         context_saved <= 1'b0;
         return_from_handler_instr <= 1'b0;
      end else begin
         return_from_handler_instr <= ret_go;
         context_saved <= (cnt_r == 4'h1);
         if (context_push) cnt_r <= slow ? 4'h8 : 4'h1;
         else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule
`default_nettype wire

// ===== sim/fsic_top_tb.sv
// fsic_top_tb: self-checking bench for fsic_top
// assumes: fsic_cpu_model stands in for the cpu
`timescale 1ns/1ps
`default_nettype none
module fsic_top_tb;
   logic clock, reset_n, pin, wr, t1, t2, s1, s2, sr, halt, bnd, slow, go;
   logic [3:0] idx, wd, rd, flags;
   logic push, pop, saved, ret, vld, inh;
   logic [10:0] vec;
   int err_total = 0, samples_checked = 0, cyc = 0;
   fsic_top dut (.clock(clock), .reset_n(reset_n), .external_request_pin(pin),
      .periph_index(idx), .periph_write(wr), .periph_wdata(wd), .periph_rdata(rd),
      .timer1_overflow(t1), .timer2_overflow(t2), .timer1_start(s1), .timer2_start(s2),
      .serial_tx_end(sr), .halt_standby(halt), .instr_boundary(bnd),
      .return_from_handler_instr(ret), .context_saved(saved), .context_push(push),
      .context_pop(pop), .vector_load(vld), .vector_addr(vec), .in_handler(inh),
      .request_flags(flags));
   fsic_cpu_model cpu (.clock(clock), .reset_n(reset_n), .slow(slow), .ret_go(go),
      .context_push(push), .context_saved(saved), .return_from_handler_instr(ret));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic end_of_test;
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wreg(input logic [3:0] d);
      @(posedge clock);
      wr <= 1'b1;
      wd <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   // pulse order: timer1, timer2, serial, start1, start2
   task automatic ev(input logic [4:0] m);
      @(posedge clock);
      {t1, t2, sr, s1, s2} <= m;
      @(posedge clock);
      {t1, t2, sr, s1, s2} <= 5'h0;
   endtask
   task automatic serve(input logic [10:0] v, input int b);
      for (int i = 0; i < 20 && vld !== 1'b1; i++) tick(1);
      chk(11'(vld), 11'h1);
      chk(vec, v);
      @(posedge clock);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      tick(2);
      chk(11'(pop), 11'h1);
      chk(11'(inh), 11'h0);
      chk(11'(flags[b]), 11'h0);
   endtask
   task automatic t_reg;
      tick(1);
      chk(11'(rd), 11'h0);
      wreg(4'hf);
      tick(1);
      chk(11'(rd), 11'hf);
      @(posedge clock);
      idx <= 4'h0;
      tick(1);
      chk(11'(rd), 11'h0);
      @(posedge clock);
      idx <= 4'ha;
      wreg(4'h0);
   endtask
   task automatic t_prio;
      ev(5'b11100);
      wreg(4'hf);
      tick(3);
      chk(11'(flags), 11'h0);
      @(posedge clock);
      pin <= 1'b1;
      ev(5'b11100);
      tick(4);
      chk(11'(flags), 11'hf);
      @(posedge clock);
      bnd <= 1'b1;
      serve(11'h010, 0);
      serve(11'h020, 1);
      serve(11'h030, 2);
      serve(11'h040, 3);
   endtask
   task automatic t_halt;
      @(posedge clock);
      pin <= 1'b0;
      halt <= 1'b1;
      tick(3);
      @(posedge clock);
      pin <= 1'b1;
      tick(6);
      chk(11'(inh), 11'h0);
      chk(11'(flags), 11'h1);
      @(posedge clock);
      halt <= 1'b0;
      serve(11'h010, 0);
   endtask
   task automatic t_start;
      @(posedge clock);
      bnd <= 1'b0;
      ev(5'b11000);
      tick(1);
      chk(11'(flags), 11'h6);
      ev(5'b00011);
      tick(1);
      chk(11'(flags), 11'h0);
   endtask
   task automatic t_pend;
      @(posedge clock);
      bnd <= 1'b1;
      slow <= 1'b1;
      ev(5'b01000);
      ev(5'b00100);
      wreg(4'h0);
      serve(11'h030, 2);
      tick(8);
      chk(11'(inh), 11'h0);
      chk(11'(flags), 11'h8);
      wreg(4'h5);
      @(posedge clock);
      reset_n <= 1'b0;
      @(posedge clock);
      reset_n <= 1'b1;
      tick(1);
      chk(11'(flags), 11'h0);
      chk(11'(rd), 11'h0);
   endtask
   initial begin
      {reset_n, pin, wr, t1, t2, s1, s2, sr, halt, bnd, slow, go} = '0;
      idx = 4'ha;
      wd = 4'h0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      t_reg();
      t_prio();
      t_halt();
      t_start();
      t_pend();
      end_of_test();
   end
endmodule
bind fsic_top fsic_monitor mon (.clock(clock), .reset_n(reset_n),
   .periph_index(periph_index), .periph_write(periph_write),
   .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
   .halt_standby(halt_standby), .return_from_handler_instr(return_from_handler_instr),
   .context_saved(context_saved), .context_push(context_push), .context_pop(context_pop),
   .vector_load(vector_load), .vector_addr(vector_addr), .in_handler(in_handler),
   .request_flags(request_flags));
`default_nettype wire
